/* File: src/fan_lut_upper_entries.sv */
// Register bank and selection logic for lookup-table entries 11 and 12
// of the fan-speed table.
// Assumes a management-interface engine on the same clock drives the
// register port with one-cycle strobes, and that the table-control,
// offset, mode and PWM frequency settings come from elsewhere in the
// device on the same clock.
`timescale 1ns/1ps
`include "fan_lut_map.svh"

module fan_lut_upper_entries
  import fan_lut_pkg::*;
(
  // Clock and reset.
  input  wire logic                clk,
  input  wire logic                rstn,
  // Register port from the management interface engine.
  input  wire logic [7:0]          reg_addr,
  input  wire logic [7:0]          reg_wdata,
  input  wire logic                reg_wr,
  input  wire logic                reg_rd,
  output logic      [7:0]          reg_rdata,
  output logic                     reg_rvalid,
  output logic                     reg_wr_ignored,
  // Settings held elsewhere in the device.
  input  wire logic [7:0]          table_ctrl,
  input  wire logic                temp_hi_res,
  input  wire logic                duty_hi_res,
  input  wire logic                pwm_freq_22k5,
  input  wire logic [7:0]          lut_temp_offset,
  // Remote diode reading, 1/8 degree per LSB, non-negative.
  input  wire logic [`TEMP_W-1:0]  remote_temp,
  // Table result towards the PWM generator.
  output logic      [7:0]          lut_duty,
  output logic                     lut_hit_11,
  output logic                     lut_hit_12
);

  top_state_t state;
  top_state_t next_state;

  logic                  write_unlocked;
  logic                  hit_limit_11;
  logic                  hit_duty_11;
  logic                  hit_limit_12;
  logic                  hit_duty_12;
  logic                  mapped;
  logic                  duty_hi_eff;
  logic [`CMP_W-1:0]     temp_half;
  logic [`CMP_W-1:0]     offset_half;
  logic [7:0]            read_mux;
  logic [7:0]            duty_sel;
  logic [`LUT_ENTRIES-1:0] over_vec;
  logic [7:0]            limit_rd [`LUT_ENTRIES];
  logic [7:0]            duty_rd  [`LUT_ENTRIES];
  logic [7:0]            duty_eff [`LUT_ENTRIES];

  // Address decode for the four entry registers.
  always_comb begin
    hit_limit_11 = reg_addr == `LUT_TEMP_LIMIT_11_ADDR;
    hit_duty_11  = reg_addr == `LUT_DUTY_11_ADDR;
    hit_limit_12 = reg_addr == `LUT_TEMP_LIMIT_12_ADDR;
    hit_duty_12  = reg_addr == `LUT_DUTY_12_ADDR;
    mapped       = hit_limit_11 | hit_duty_11 |
                   hit_limit_12 | hit_duty_12;
  end

  // The unlock bit is sampled in the write cycle itself, so clearing it
  // in the same cycle as a write already blocks that write.
  assign write_unlocked = table_ctrl[`LUT_CTRL_WE_BIT];

  // The extended duty path needs both the mode and the fast PWM rate;
  // at other rates the six-bit path is used even in high resolution.
  assign duty_hi_eff = duty_hi_res & pwm_freq_22k5;

  // Reading in half-degree units. Low resolution drops the half bit so
  // that only the eight whole-degree bits take part.
  always_comb begin
    if (temp_hi_res) begin
      temp_half = {1'b0, remote_temp[`TEMP_W-1:`TEMP_HI_LSB]};
    end else begin
      temp_half = {1'b0, remote_temp[`TEMP_W-1:`TEMP_LO_LSB],
                   1'b0};
    end
  end

  // Offset is whole degrees; doubling puts it on the half-degree grid.
  assign offset_half = {1'b0, lut_temp_offset, 1'b0};

  // One slot per entry; index 0 is entry 11, index 1 is entry 12.
  generate
    for (genvar i = 0; i < `LUT_ENTRIES; i++) begin : g_slot
      lut_entry_if ent ();

      assign ent.wr_limit = reg_wr & write_unlocked &
                            (i == 0 ? hit_limit_11
                                    : hit_limit_12);
      assign ent.wr_duty  = reg_wr & write_unlocked &
                            (i == 0 ? hit_duty_11
                                    : hit_duty_12);
      assign ent.wdata       = reg_wdata;
      assign ent.temp_hi_res = temp_hi_res;
      assign ent.duty_hi_res = duty_hi_res;
      assign ent.duty_hi_eff = duty_hi_eff;
      assign ent.temp_half   = temp_half;
      assign ent.offset_half = offset_half;
      assign limit_rd[i]     = ent.limit_rd;
      assign duty_rd[i]      = ent.duty_rd;
      assign duty_eff[i]     = ent.duty_eff;
      assign over_vec[i]     = ent.over;

      lut_entry_slot lut_entry_slot_inst (
        .clk  (clk),
        .rstn (rstn),
        .ent  (ent.slot_end)
      );
    end
  endgenerate

  // Readback multiplexer; an unmapped address answers with zero.
  always_comb begin
    read_mux = `UNMAPPED_DATA;
    if (hit_limit_11) begin
      read_mux = limit_rd[0];
    end else if (hit_duty_11) begin
      read_mux = duty_rd[0];
    end else if (hit_limit_12) begin
      read_mux = limit_rd[1];
    end else if (hit_duty_12) begin
      read_mux = duty_rd[1];
    end
  end

  // Entry 12 sits higher in the table, so it wins when both limits are
  // exceeded. With neither exceeded the lower table entries decide and
  // this block reports no hit; the duty output then holds zero.
  always_comb begin
    duty_sel = 8'h00;
    if (over_vec[1]) begin
      duty_sel = duty_eff[1];
    end else if (over_vec[0]) begin
      duty_sel = duty_eff[0];
    end
  end

  // Next-state fill for the registered outputs.
  always_comb begin
    next_state            = state;
    next_state.rvalid     = reg_rd;
    next_state.wr_ignored = reg_wr & mapped & ~write_unlocked;
    if (reg_rd) begin
      next_state.rdata = read_mux;
    end
    next_state.duty   = duty_sel;
    next_state.hit_11 = over_vec[0] & ~over_vec[1];
    next_state.hit_12 = over_vec[1];
  end

  // State register.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  // Outputs straight from the state register.
  assign reg_rdata      = state.rdata;
  assign reg_rvalid     = state.rvalid;
  assign reg_wr_ignored = state.wr_ignored;
  assign lut_duty       = state.duty;
  assign lut_hit_11     = state.hit_11;
  assign lut_hit_12     = state.hit_12;

endmodule

/* File: common/fan_lut_map.svh */
// Offsets, field positions, reset values and widths for the upper
// fan lookup-table entries (entries 11 and 12).
// Assumes an 8-bit register address space reached by the management
// interface engine.
`ifndef FAN_LUT_MAP_SVH
`define FAN_LUT_MAP_SVH

// Register offsets.
`define LUT_TEMP_LIMIT_11_ADDR 8'h64
`define LUT_DUTY_11_ADDR       8'h65
`define LUT_TEMP_LIMIT_12_ADDR 8'h66
`define LUT_DUTY_12_ADDR       8'h67

// Reset values.
`define LUT_TEMP_LIMIT_RESET   8'h7f
`define LUT_DUTY_RESET         8'h3f

// Temperature limit fields.
`define LIMIT_HALF_BIT         7
`define LIMIT_MAIN_MSB         6

// Duty fields.
`define DUTY_EXT_MSB           7
`define DUTY_EXT_LSB           6
`define DUTY_BASE_MSB          5

// Table-control register bit that unlocks table writes.
`define LUT_CTRL_WE_BIT        5

// Remote reading layout: 11 bits, 1/8 degree per LSB.
`define TEMP_W                 11
`define TEMP_HI_LSB            2
`define TEMP_LO_LSB            3

// Width of the half-degree comparison domain.
`define CMP_W                  10

// Number of table entries held by this block.
`define LUT_ENTRIES            2

// Reading with no mapped register returns this.
`define UNMAPPED_DATA          8'h00

`endif

/* File: common/fan_lut_pkg.sv */
// Types shared by the upper lookup-table entry logic.
// Assumes fan_lut_map.svh supplies the numeric constants.
`include "fan_lut_map.svh"

package fan_lut_pkg;

  // Stored contents of one table entry.
  typedef struct packed {
    logic [7:0] limit;
    logic [7:0] duty;
  } slot_state_t;

  // Registered outputs of the top block.
  typedef struct packed {
    logic [7:0] rdata;
    logic       rvalid;
    logic       wr_ignored;
    logic [7:0] duty;
    logic       hit_11;
    logic       hit_12;
  } top_state_t;

endpackage

/* File: common/lut_entry_if.sv */
// Carrier between the table block and one entry slot.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`include "fan_lut_map.svh"

interface lut_entry_if;
  logic                wr_limit;
  logic                wr_duty;
  logic [7:0]          wdata;
  logic                temp_hi_res;
  logic                duty_hi_eff;
  logic                duty_hi_res;
  logic [`CMP_W-1:0]   temp_half;
  logic [`CMP_W-1:0]   offset_half;
  logic [7:0]          limit_rd;
  logic [7:0]          duty_rd;
  logic                over;
  logic [7:0]          duty_eff;

  modport table_end (
    output wr_limit, wr_duty, wdata, temp_hi_res, duty_hi_eff,
           duty_hi_res, temp_half, offset_half,
    input  limit_rd, duty_rd, over, duty_eff
  );

  modport slot_end (
    input  wr_limit, wr_duty, wdata, temp_hi_res, duty_hi_eff,
           duty_hi_res, temp_half, offset_half,
    output limit_rd, duty_rd, over, duty_eff
  );
endinterface

/* File: src/lut_entry_slot.sv */
// One lookup-table entry: a temperature limit and its paired duty.
// Assumes the table block gates writes and supplies the mode levels.
`timescale 1ns/1ps
`include "fan_lut_map.svh"

module lut_entry_slot
  import fan_lut_pkg::*;
(
  // Clock and reset.
  input  wire logic clk,
  input  wire logic rstn,
  // Link to the table block.
  lut_entry_if.slot_end ent
);

  slot_state_t state;
  slot_state_t next_state;
  logic [7:0]        lim_half;
  logic [`CMP_W-1:0] lim_eff;

  // Write path: writes arrive already gated by the unlock bit.
  always_comb begin
    next_state = state;
    if (ent.wr_limit) begin
      next_state.limit = ent.wdata;
    end
    if (ent.wr_duty) begin
      next_state.duty = ent.wdata;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state.limit <= `LUT_TEMP_LIMIT_RESET;
      state.duty  <= `LUT_DUTY_RESET;
    end else begin
      state <= next_state;
    end
  end

  // Readback hides the bits that the current mode leaves unused.
  always_comb begin
    ent.limit_rd = state.limit;
    ent.duty_rd  = state.duty;
    if (!ent.temp_hi_res) begin
      ent.limit_rd[`LIMIT_HALF_BIT] = 1'b0;
    end
    if (!ent.duty_hi_res) begin
      ent.duty_rd[`DUTY_EXT_MSB:`DUTY_EXT_LSB] = 2'b00;
    end
  end

  // Limit in half-degree units; the sign bit is always taken as zero,
  // so the limit can never be negative.
  always_comb begin
    if (ent.temp_hi_res) begin
      lim_half = {state.limit[`LIMIT_MAIN_MSB:0],
                  state.limit[`LIMIT_HALF_BIT]};
    end else begin
      lim_half = {state.limit[`LIMIT_MAIN_MSB:0], 1'b0};
    end
    lim_eff = {2'b00, lim_half} + ent.offset_half;
  end

  // Strictly above the limit selects this entry.
  assign ent.over = ent.temp_half > lim_eff;

  // Extended duty bits count only when the high-resolution duty path
  // is allowed; otherwise the six base bits alone form the value.
  assign ent.duty_eff = ent.duty_hi_eff ? state.duty
                      : {2'b00, state.duty[`DUTY_BASE_MSB:0]};

endmodule

/* File: test/fan_lut_upper_entries_properties.sv */
// Checker for the upper lookup-table entry block.
// Assumes it is bound to fan_lut_upper_entries and sees only its ports.
`timescale 1ns/1ps
`include "fan_lut_map.svh"

module fan_lut_checker (
  // Clock and reset.
  input wire logic               clk,
  input wire logic               rstn,
  // Register port.
  input wire logic [7:0]         reg_addr,
  input wire logic               reg_wr,
  input wire logic               reg_rd,
  input wire logic [7:0]         reg_rdata,
  input wire logic               reg_rvalid,
  input wire logic               reg_wr_ignored,
  // Settings and reading.
  input wire logic [7:0]         table_ctrl,
  input wire logic               temp_hi_res,
  input wire logic               duty_hi_res,
  input wire logic               pwm_freq_22k5,
  input wire logic [`TEMP_W-1:0] remote_temp,
  // Table result.
  input wire logic [7:0]         lut_duty,
  input wire logic               lut_hit_11,
  input wire logic               lut_hit_12
);
  // One clock domain, so clocking and reset are declared once.
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // High when the address falls on one of the four entry registers.
  logic mapped;
  logic locked;
  assign mapped = reg_addr[7:2] == 6'h19;
  // High while the unlock bit is clear and entry writes are refused.
  assign locked = !table_ctrl[`LUT_CTRL_WE_BIT];

  a_read_answer: assert property (reg_rd |=> reg_rvalid)
    else $error("read strobe not answered");
  a_answer_cause: assert property (reg_rvalid |-> $past(reg_rd))
    else $error("read answer without a read");
  a_locked_write: assert property (reg_wr && mapped && locked |=>
    reg_wr_ignored)
    else $error("locked write not flagged");
  a_refusal_cause: assert property (reg_wr_ignored |->
    $past(reg_wr) && $past(locked))
    else $error("refusal without a locked write");
  a_limit_mask: assert property (reg_rd && !temp_hi_res && mapped &&
    !reg_addr[0] |=> !reg_rdata[7])
    else $error("limit top bit not masked");
  a_duty_mask: assert property (reg_rd && !duty_hi_res && mapped &&
    reg_addr[0] |=> reg_rdata[7:6] == 2'b00)
    else $error("duty upper bits not masked");
  a_unmapped_zero: assert property (reg_rd && !mapped |=>
    reg_rdata == `UNMAPPED_DATA)
    else $error("unmapped read not zero");
  a_hit_single: assert property (!(lut_hit_11 && lut_hit_12))
    else $error("both entries flagged");
  a_idle_duty: assert property (!lut_hit_11 && !lut_hit_12 |->
    lut_duty == 8'h00)
    else $error("duty driven without a hit");
  a_ext_gate: assert property (!(duty_hi_res && pwm_freq_22k5) |=>
    lut_duty[7:6] == 2'b00)
    else $error("extended duty bits leaked");
  a_cold_reading: assert property (remote_temp == '0 |=>
    !lut_hit_11 && !lut_hit_12)
    else $error("zero reading exceeded a limit");

  // Main scenarios that the bench should reach.
  c_hit_11: cover property (lut_hit_11);
  c_hit_12: cover property (lut_hit_12);
  c_refused: cover property (reg_wr_ignored);
endmodule

bind fan_lut_upper_entries fan_lut_checker fan_lut_checker_inst (
  .clk, .rstn, .reg_addr, .reg_wr, .reg_rd, .reg_rdata, .reg_rvalid,
  .reg_wr_ignored, .table_ctrl, .temp_hi_res, .duty_hi_res,
  .pwm_freq_22k5, .remote_temp, .lut_duty, .lut_hit_11, .lut_hit_12);

/* File: test/fan_lut_upper_entries_tb.sv */
// Self-checking bench for the upper lookup-table entry block.
// Assumes the design, its package and its checker are compiled first.
`timescale 1ns/1ps
`include "fan_lut_map.svh"

module fan_lut_upper_entries_tb;
  logic clk, rstn, reg_wr, reg_rd, reg_rvalid, reg_wr_ignored;
  logic temp_hi_res, duty_hi_res, pwm_freq_22k5, lut_hit_11, lut_hit_12;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, table_ctrl;
  logic [7:0] lut_temp_offset, lut_duty;
  logic [`TEMP_W-1:0] remote_temp;
  logic [7:0] sh [4];
  logic [9:0] rd_q [$];
  logic [9:0] tab_q [$];
  logic [9:0] tab_seen;
  // Table result as one word: {hit 12, hit 11, duty}.
  assign tab_seen = {lut_hit_12, lut_hit_11, lut_duty};
  int n_fail, checks, cyc, n_ig, ig_seen, i, k;

  fan_lut_upper_entries fan_lut_upper_entries_inst (
    .clk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .reg_rvalid, .reg_wr_ignored, .table_ctrl, .temp_hi_res, .duty_hi_res,
    .pwm_freq_22k5, .lut_temp_offset, .remote_temp, .lut_duty,
    .lut_hit_11, .lut_hit_12);

  task automatic chk(input logic [9:0] seen, input logic [9:0] exp,
                     input string nm);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic complete_run;
    chk(10'(ig_seen), 10'(n_ig), "refused writes");
    if (n_fail == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Readback as the current modes show it; storage keeps every bit.
  function automatic logic [9:0] rexp(input logic [7:0] a);
    if (a[7:2] != 6'h19) return 10'(`UNMAPPED_DATA);
    if (a[0]) return 10'(duty_hi_res ? sh[a[1:0]] : sh[a[1:0]] & 8'h3f);
    return 10'(temp_hi_res ? sh[a[1:0]] : sh[a[1:0]] & 8'h7f);
  endfunction

  // Table result worked out in half degrees: {hit 12, hit 11, duty}.
  function automatic logic [9:0] texp();
    logic [9:0] t, l;
    logic [7:0] d;
    logic [1:0] h;
    t = temp_hi_res ? 10'(remote_temp[10:2])
                    : {1'b0, remote_temp[10:3], 1'b0};
    for (int e = 0; e < 2; e++) begin
      l = temp_hi_res ? {2'b0, sh[2*e][6:0], sh[2*e][7]}
                      : {2'b0, sh[2*e][6:0], 1'b0};
      l = l + {1'b0, lut_temp_offset, 1'b0};
      h[e] = t > l;
    end
    d = h[1] ? sh[3] : h[0] ? sh[1] : 8'h00;
    if (!(duty_hi_res && pwm_freq_22k5)) d[7:6] = 2'b00;
    return {h[1], h[0] && !h[1], d};
  endfunction

  // One register cycle; the strobes stay as set until the next call.
  task automatic op(input logic r, input logic w, input logic [7:0] a,
                    input logic [7:0] d);
    @(posedge clk);
    reg_rd <= r;
    reg_wr <= w;
    reg_addr <= a;
    reg_wdata <= d;
    if (r) rd_q.push_back(rexp(a));
    if (w && a[7:2] == 6'h19) begin
      if (table_ctrl[`LUT_CTRL_WE_BIT]) sh[a[1:0]] = d;
      else n_ig++;
    end
  endtask

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Watcher: compares each answer with the oldest note, and bounds the run.
  always @(posedge clk) begin
    cyc++;
    if (reg_rvalid === 1'b1)
      chk(10'(reg_rdata), rd_q.pop_front(), "rdata");
    if (reg_wr_ignored === 1'b1) ig_seen++;
    if (cyc == 20000) begin
      n_fail++;
      complete_run();
    end
  end
  always @(negedge clk)
    while (tab_q.size() > 0)
      chk(tab_seen, tab_q.pop_front(), "table");

  initial begin
    {rstn, reg_wr, reg_rd, temp_hi_res, duty_hi_res, pwm_freq_22k5} = '0;
    {reg_addr, reg_wdata, table_ctrl, lut_temp_offset} = '0;
    remote_temp = '0;
    sh = '{8'h7f, 8'h3f, 8'h7f, 8'h3f};
    void'($urandom(98044));
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    // Reset values and unmapped reads in every readback mode.
    for (k = 0; k < 4; k++) begin
      @(posedge clk);
      {duty_hi_res, temp_hi_res} <= 2'(k);
      for (i = 8'h62; i < 8'h6a; i++) op(1'b1, 1'b0, 8'(i), 8'h00);
      // Drop the strobe so that the idle edge below takes no extra read.
      op(1'b0, 1'b0, 8'h00, 8'h00);
    end
    // Locked writes, with every other control bit set, change nothing.
    table_ctrl <= 8'hdf;
    for (i = 8'h63; i < 8'h69; i++) op(1'b0, 1'b1, 8'(i), 8'hff);
    op(1'b0, 1'b0, 8'h00, 8'h00);
    // Random entries, modes and readings near the thresholds.
    for (k = 0; k < 150; k++) begin
      @(posedge clk);
      {pwm_freq_22k5, duty_hi_res, temp_hi_res} <= 3'($urandom);
      table_ctrl <= (k % 8 == 7) ? 8'h00 : 8'h20;
      lut_temp_offset <= 8'($urandom_range(0, 63));
      for (i = 0; i < 4; i++) op(1'b0, 1'b1, 8'h64 + 8'(i), 8'($urandom));
      op(1'b1, 1'b1, 8'h64 + 8'($urandom_range(0, 3)), 8'($urandom));
      for (i = 0; i < 4; i++) op(1'b1, 1'b0, 8'h64 + 8'(i), 8'h00);
      op(1'b0, 1'b0, 8'h00, 8'h00);
      remote_temp <= (k % 5 == 4) ? '0 : 11'(8 * (sh[2 * (k % 2)][6:0] +
        lut_temp_offset) + $urandom_range(0, 23) - 8);
      repeat (2) @(posedge clk);
      #1 tab_q.push_back(texp());
    end
    repeat (3) @(posedge clk);
    complete_run();
  end
endmodule
